//--- verilog/fwd_table_regs.vh
// constants for the address forwarding table with aging
`ifndef FWD_TABLE_REGS_VH
`define FWD_TABLE_REGS_VH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ            25000000
// aging period after reset, 300 seconds
`define AGE_DEFAULT_S     16'h012C
`define AGE_SEC_CYCLES    (`CLK_HZ)
// ----------------------------------------------------------------
// field widths
// ----------------------------------------------------------------
`define ADDR_W            48
`define VLAN_W            12
`define AGE_W             16
`define BCAST_ADDR        48'hFFFFFFFFFFFF
`endif

//--- verilog/sec_tick.v
// one-cycle pulse once per second of the system clock
`timescale 1ns/1ps
`include "fwd_table_regs.vh"
module sec_tick #(
  parameter CYCLES = `AGE_SEC_CYCLES
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // divided enable
  output reg  tick
);
  reg [31:0] count_reg;   // cycles within the current second

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      count_reg <= 32'h00000000;
      tick      <= 1'b0;
    end else if (count_reg >= CYCLES - 1) begin
      count_reg <= 32'h00000000;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h00000001;
      tick      <= 1'b0;
    end
  end
endmodule

//--- verilog/fwd_table.v
// layer-2 forwarding table with learning, aging, static and filter entries
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "fwd_table_regs.vh"
module fwd_table #(
  parameter ENTRIES = 16,                 // table depth
  parameter IDX_W   = 4,                  // log2 of depth
  parameter PORTS   = 20,                 // switch port count
  parameter PORT_W  = 5,                  // port number width
  parameter SEC_CYCLES = `AGE_SEC_CYCLES  // cycles per second
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst,
  // frame descriptor from ingress
  input  wire                 frm_valid,
  output wire                 frm_ready,
  input  wire [`ADDR_W-1:0]   frm_dst,
  input  wire [`ADDR_W-1:0]   frm_src,
  input  wire [`VLAN_W-1:0]   frm_vlan,
  input  wire [PORT_W-1:0]    frm_port,
  // forwarding decision to egress
  output reg                  fwd_valid,
  output reg  [PORTS-1:0]     fwd_mask,
  output reg                  fwd_drop,
  output reg                  fwd_hit,
  // aging configuration
  input  wire                 age_wr,
  input  wire [`AGE_W-1:0]    age_val,
  output reg  [`AGE_W-1:0]    age_time_reg,
  // manual entry write (static or filter)
  input  wire                 cfg_wr,
  input  wire [IDX_W-1:0]     cfg_idx,
  input  wire                 cfg_valid,
  input  wire                 cfg_static,
  input  wire                 cfg_filter,
  input  wire [`ADDR_W-1:0]   cfg_addr,
  input  wire [`VLAN_W-1:0]   cfg_vlan,
  input  wire [PORT_W-1:0]    cfg_port,
  // status
  output reg  [IDX_W:0]       used_count
);
  // ------------------------------------------------------------
  // table storage
  // ------------------------------------------------------------
  reg [`ADDR_W-1:0] addr_mem   [0:ENTRIES-1]; // station address
  reg [`VLAN_W-1:0] vlan_mem   [0:ENTRIES-1]; // vlan number
  reg [PORT_W-1:0]  port_mem   [0:ENTRIES-1]; // egress port
  reg [`AGE_W-1:0]  age_mem    [0:ENTRIES-1]; // seconds since refresh
  reg [ENTRIES-1:0] valid_reg;                // entry in use
  reg [ENTRIES-1:0] static_reg;               // never aged
  reg [ENTRIES-1:0] filter_reg;               // discard on match
  reg [IDX_W-1:0]   repl_reg;                 // round-robin victim
  wire              sec_en;                   // one-second enable

  // the frame path takes one descriptor per cycle
  assign frm_ready = 1'b1;

  sec_tick #(
    .CYCLES (SEC_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (sec_en)
  );

  // ------------------------------------------------------------
  // matching function
  // ------------------------------------------------------------
  // one entry against an address and vlan pair
  function hit_one;
    input               ok;  // entry in use
    input [`ADDR_W-1:0] ea;  // entry address
    input [`VLAN_W-1:0] ev;  // entry vlan
    input [`ADDR_W-1:0] a;   // looked-up address
    input [`VLAN_W-1:0] v;   // looked-up vlan
    begin
      hit_one = ok && ea == a && ev == v;
    end
  endfunction

  // lowest set bit index of a hit vector
  function [IDX_W-1:0] first;
    input [ENTRIES-1:0] h;
    integer k;
    begin
      first = {IDX_W{1'b0}};
      for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
        if (h[k]) begin
          first = k[IDX_W-1:0];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // lookup combinational
  // ------------------------------------------------------------
  // table reads stay in the process so a learn or an expiry is seen
  // at once even when the descriptor fields do not change
  reg [ENTRIES-1:0] dst_hits;  // destination hit per entry
  reg [ENTRIES-1:0] src_hits;  // source hit per entry
  integer m;
  always @* begin
    dst_hits = {ENTRIES{1'b0}};
    src_hits = {ENTRIES{1'b0}};
    for (m = 0; m < ENTRIES; m = m + 1) begin
      dst_hits[m] = hit_one(valid_reg[m], addr_mem[m], vlan_mem[m],
                            frm_dst, frm_vlan);
      src_hits[m] = hit_one(valid_reg[m], addr_mem[m], vlan_mem[m],
                            frm_src, frm_vlan);
    end
  end
  wire [IDX_W-1:0]   dst_idx  = first(dst_hits);
  wire [IDX_W-1:0]   src_idx  = first(src_hits);
  wire               dst_hit  = |dst_hits;
  wire               src_hit  = |src_hits;
  wire               is_bcast = frm_dst == `BCAST_ADDR;
  wire               take     = frm_valid && frm_ready;

  // free slot search, else round-robin victim among dynamic entries
  reg [IDX_W-1:0] free_idx;
  reg             free_any;
  integer j;
  always @* begin
    free_idx = repl_reg;
    free_any = 1'b0;
    for (j = ENTRIES - 1; j >= 0; j = j - 1) begin
      if (!valid_reg[j]) begin
        free_idx = j[IDX_W-1:0];
        free_any = 1'b1;
      end
    end
  end
  // never overwrite a static or filter entry when learning
  wire learn_ok = free_any ||
                  !(static_reg[repl_reg] || filter_reg[repl_reg]);

  // ------------------------------------------------------------
  // forwarding decision
  // ------------------------------------------------------------
  reg [PORTS-1:0] flood;   // all ports but the ingress
  always @* begin
    flood = {PORTS{1'b1}};
    flood[frm_port] = 1'b0;
  end

  always @(posedge clk) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      fwd_mask  <= {PORTS{1'b0}};
      fwd_drop  <= 1'b0;
      fwd_hit   <= 1'b0;
    end else begin
      fwd_valid <= take;
      if (take) begin
        if (is_bcast || !dst_hit) begin
          fwd_mask <= flood;
          fwd_drop <= 1'b0;
          fwd_hit  <= 1'b0;
        end else if (filter_reg[dst_idx]) begin
          fwd_mask <= {PORTS{1'b0}};
          fwd_drop <= 1'b1;
          fwd_hit  <= 1'b1;
        end else begin
          fwd_mask <= {{(PORTS-1){1'b0}}, 1'b1}
                      << port_mem[dst_idx];
          fwd_drop <= 1'b0;
          fwd_hit  <= 1'b1;
        end
        if (src_hit && filter_reg[src_idx]) begin
          fwd_mask <= {PORTS{1'b0}};
          fwd_drop <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // aging period setting
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      age_time_reg <= `AGE_DEFAULT_S;
    end else if (age_wr) begin
      age_time_reg <= age_val;
    end
  end

  // ------------------------------------------------------------
  // table update: config, learning, aging
  // ------------------------------------------------------------
  integer i;
  always @(posedge clk) begin
    if (rst) begin
      valid_reg  <= {ENTRIES{1'b0}};
      static_reg <= {ENTRIES{1'b0}};
      filter_reg <= {ENTRIES{1'b0}};
      repl_reg   <= {IDX_W{1'b0}};
    end else begin
      // aging pass, once per second
      if (sec_en) begin
        for (i = 0; i < ENTRIES; i = i + 1) begin
          if (valid_reg[i] && !static_reg[i] && !filter_reg[i]) begin
            if (age_mem[i] + 16'h0001 >= age_time_reg) begin
              valid_reg[i] <= 1'b0;
            end else begin
              age_mem[i] <= age_mem[i] + 16'h0001;
            end
          end
        end
      end
      // learning from the source address
      if (take && src_hit) begin
        if (!static_reg[src_idx] && !filter_reg[src_idx]) begin
          age_mem[src_idx]   <= {`AGE_W{1'b0}};
          valid_reg[src_idx] <= 1'b1;
          port_mem[src_idx]  <= frm_port;
        end
      end else if (take && learn_ok) begin
        addr_mem[free_idx]   <= frm_src;
        vlan_mem[free_idx]   <= frm_vlan;
        port_mem[free_idx]   <= frm_port;
        age_mem[free_idx]    <= {`AGE_W{1'b0}};
        valid_reg[free_idx]  <= 1'b1;
        static_reg[free_idx] <= 1'b0;
        filter_reg[free_idx] <= 1'b0;
        if (!free_any) begin
          repl_reg <= repl_reg + {{(IDX_W-1){1'b0}}, 1'b1};
        end
      end else if (take) begin
        repl_reg <= repl_reg + {{(IDX_W-1){1'b0}}, 1'b1};
      end
      // manual write wins over learning on the same slot
      if (cfg_wr) begin
        addr_mem[cfg_idx]   <= cfg_addr;
        vlan_mem[cfg_idx]   <= cfg_vlan;
        port_mem[cfg_idx]   <= cfg_port;
        age_mem[cfg_idx]    <= {`AGE_W{1'b0}};
        valid_reg[cfg_idx]  <= cfg_valid;
        static_reg[cfg_idx] <= cfg_static;
        filter_reg[cfg_idx] <= cfg_filter;
      end
    end
  end

  // ------------------------------------------------------------
  // occupancy status
  // ------------------------------------------------------------
  integer c;
  reg [IDX_W:0] cnt;
  always @* begin
    cnt = {(IDX_W+1){1'b0}};
    for (c = 0; c < ENTRIES; c = c + 1) begin
      cnt = cnt + {{IDX_W{1'b0}}, valid_reg[c]};
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      used_count <= {(IDX_W+1){1'b0}};
    end else begin
      used_count <= cnt;
    end
  end
endmodule

//--- test/fwd_table_checker.sv
// assertion checker for the forwarding table decision and aging ports
`timescale 1ns/1ps
`include "fwd_table_regs.vh"
module fwd_table_checker #(
  parameter IDX_W  = 4,
  parameter PORTS  = 20,
  parameter PORT_W = 5
) (
  // clock and reset
  input wire               clk,
  input wire               rst,
  // descriptor and decision
  input wire               frm_valid,
  input wire [`ADDR_W-1:0] frm_dst,
  input wire [PORT_W-1:0]  frm_port,
  input wire               fwd_valid,
  input wire [PORTS-1:0]   fwd_mask,
  input wire               fwd_drop,
  input wire               fwd_hit,
  // aging setting
  input wire               age_wr,
  input wire [`AGE_W-1:0]  age_val,
  input wire [`AGE_W-1:0]  age_time_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // every port but the ingress one
  wire [PORTS-1:0] flood;
  assign flood = ~({{(PORTS-1){1'b0}}, 1'b1} << frm_port);
  // a taken descriptor, and one with an all-ones destination
  sequence s_take;
    frm_valid;
  endsequence
  sequence s_bcast;
    frm_valid && frm_dst == `BCAST_ADDR;
  endsequence
  sequence s_miss;
    s_take ##1 (!fwd_hit && !fwd_drop);
  endsequence
  a_answer_next: assert property (s_take |=> fwd_valid)
    else $error("no decision after take");
  a_idle_quiet: assert property (!frm_valid |=> !fwd_valid)
    else $error("decision without take");
  a_bcast_flood: assert property (s_bcast |=>
    fwd_drop || (!fwd_hit && fwd_mask == $past(flood)))
    else $error("broadcast not flooded");
  a_miss_flood: assert property (
    s_miss |-> fwd_mask == $past(flood))
    else $error("miss not flooded");
  a_hit_single: assert property (
    fwd_valid && fwd_hit && !fwd_drop |-> $onehot(fwd_mask))
    else $error("hit not single port");
  a_drop_empty: assert property (
    fwd_valid && fwd_drop |-> fwd_mask == 0)
    else $error("dropped frame has ports");
  a_age_write: assert property (
    age_wr |=> age_time_reg == $past(age_val))
    else $error("aging period not taken");
  a_age_reset: assert property (
    $fell(rst) |-> age_time_reg == 16'h012C)
    else $error("aging period reset value");
endmodule

//--- test/egress_sink.sv
// egress side model: captures each forwarding decision for the bench
`timescale 1ns/1ps
module egress_sink #(
  parameter PORTS = 20
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // decision from the table
  input  wire             fwd_valid,
  input  wire [PORTS-1:0] fwd_mask,
  input  wire             fwd_drop,
  input  wire             fwd_hit,
  // last decision seen
  output reg  [PORTS+1:0] seen_reg,
  output reg              got_reg
);
  // latch a decision only in the one cycle it is valid
  always @(posedge clk) begin
    if (rst) begin
      seen_reg <= {(PORTS+2){1'b0}};
      got_reg  <= 1'b0;
    end else begin
      got_reg <= fwd_valid;
      if (fwd_valid) begin
        seen_reg <= {fwd_drop, fwd_hit, fwd_mask};
      end
    end
  end
endmodule

//--- test/tb_fwd_table.sv
// self-checking bench for the forwarding table
`timescale 1ns/1ps
`include "fwd_table_regs.vh"
module tb_fwd_table;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         frm_valid = 1'b0;
  reg  [47:0] frm_dst = 48'h0, frm_src = 48'h0;
  reg  [11:0] frm_vlan = 12'h0;
  reg  [4:0]  frm_port = 5'h0;
  reg         age_wr = 1'b0, cfg_wr = 1'b0;
  reg  [15:0] age_val = 16'h0;
  reg  [3:0]  cfg_idx = 4'h0;
  reg         cfg_static = 1'b0, cfg_filter = 1'b0;
  reg  [47:0] cfg_addr = 48'h0;
  reg  [11:0] cfg_vlan = 12'h001;
  reg  [4:0]  cfg_port = 5'h0;
  wire        frm_ready, fwd_valid, fwd_drop, fwd_hit, got_reg;
  wire [19:0] fwd_mask;
  wire [15:0] age_time_reg;
  wire [4:0]  used_count;
  wire [21:0] seen_reg;
  integer     fails = 0, n_tests = 0, cyc = 0;
  // ------------------------------------------------------------
  // design, far side model, clock and hang guard
  // ------------------------------------------------------------
  fwd_table #(.SEC_CYCLES(10)) u_dut (.clk, .rst, .frm_valid, .frm_ready,
    .frm_dst, .frm_src, .frm_vlan, .frm_port, .fwd_valid, .fwd_mask,
    .fwd_drop, .fwd_hit, .age_wr, .age_val, .age_time_reg, .cfg_wr,
    .cfg_idx, .cfg_valid(1'b1), .cfg_static, .cfg_filter, .cfg_addr,
    .cfg_vlan, .cfg_port, .used_count);
  egress_sink u_sink (.clk, .rst, .fwd_valid, .fwd_mask, .fwd_drop,
    .fwd_hit, .seen_reg, .got_reg);
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      fails = fails + 1;
      test_done;
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  function [19:0] fl(input [4:0] p);
    fl = 20'hFFFFF ^ (20'h00001 << p);
  endfunction
  task chk(input [22:0] g, input [22:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("FAIL %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // one frame, then judge what the egress model saw
  task frm(input [47:0] d, input [47:0] s, input [11:0] v,
           input [4:0] p, input [19:0] em, input ed, input eh);
    reg [21:0] g;
    begin
      @(posedge clk);
      frm_valid <= 1'b1;
      frm_dst   <= d;
      frm_src   <= s;
      frm_vlan  <= v;
      frm_port  <= p;
      @(posedge clk);
      frm_valid <= 1'b0;
      @(posedge clk);
      #1;
      g = seen_reg;
      if (ed) g[20] = eh;
      chk({got_reg, g}, {1'b1, ed, eh, em});
    end
  endtask
  task cfg(input [3:0] i, input st, input fi, input [47:0] a,
           input [4:0] p);
    begin
      @(posedge clk);
      {cfg_wr, cfg_idx, cfg_static, cfg_filter} <= {1'b1, i, st, fi};
      cfg_addr <= a;
      cfg_port <= p;
      @(posedge clk);
      cfg_wr <= 1'b0;
    end
  endtask
  task age(input [15:0] s);
    begin
      @(posedge clk);
      age_wr  <= 1'b1;
      age_val <= s;
      @(posedge clk);
      age_wr <= 1'b0;
      #1;
      chk({7'h00, age_time_reg}, {7'h00, s});
    end
  endtask
  task test_done;
    begin
      if (fails == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_flood;
    begin
      frm(`BCAST_ADDR, 48'hA1, 12'h001, 5'h03, fl(3), 0, 0);
      frm(48'hB0B0, 48'hA2, 12'h001, 5'h13, fl(19), 0, 0);
    end
  endtask
  task t_static;
    begin
      age(16'h0005);
      cfg(4'h0, 1'b1, 1'b0, 48'h5A, 5'h07);
      repeat (70) @(posedge clk);
      frm(48'h5A, 48'hA3, 12'h001, 5'h02, 20'h00080, 0, 1);
    end
  endtask
  task t_filter;
    begin
      cfg(4'h1, 1'b0, 1'b1, 48'hF1, 5'h00);
      frm(48'hF1, 48'hA4, 12'h001, 5'h04, 20'h0, 1, 0);
    end
  endtask
  // six live entries: static, filter and four learned sources
  task t_learn;
    begin
      frm(48'hE0, 48'hAA, 12'h001, 5'h05, fl(5), 0, 0);
      frm(48'hAA, 48'hAB, 12'h001, 5'h02, 20'h20, 0, 1);
      frm(48'hAA, 48'hAC, 12'h002, 5'h02, fl(2), 0, 0);
      chk({17'h0, frm_ready, used_count}, {17'h0, 1'b1, 5'h06});
    end
  endtask
  task t_aging;
    begin
      frm(48'hE1, 48'hC0, 12'h001, 5'h09, fl(9), 0, 0);
      repeat (30) @(posedge clk);
      frm(48'hE2, 48'hC0, 12'h001, 5'h09, fl(9), 0, 0);
      repeat (30) @(posedge clk);
      frm(48'hC0, 48'hC1, 12'h001, 5'h02, 20'h200, 0, 1);
      repeat (60) @(posedge clk);
      frm(48'hC0, 48'hC2, 12'h001, 5'h02, fl(2), 0, 0);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({2'b00, used_count, age_time_reg}, 23'h00012C);
    t_flood;
    t_static;
    t_filter;
    t_learn;
    t_aging;
    test_done;
  end
endmodule
bind fwd_table fwd_table_checker #(.IDX_W(IDX_W), .PORTS(PORTS),
  .PORT_W(PORT_W)) u_chk (.clk, .rst, .frm_valid, .frm_dst, .frm_port,
  .fwd_valid, .fwd_mask, .fwd_drop, .fwd_hit, .age_wr, .age_val,
  .age_time_reg);
